// ### rtl/rpsc_defs.vh
// Constants for the radio power-up and sleep controller
`ifndef RPSC_DEFS_VH
`define RPSC_DEFS_VH
`define RPSC_CLK_MHZ 100
`define RPSC_CMD_WRITE 1'b0
`define RPSC_ADDR_W 7
`define RPSC_DATA_W 16
`define RPSC_REG_INIT 7'h1B
`define RPSC_INIT_VALUE 16'h4200
`define RPSC_REG_SLEEP 7'h23
`define RPSC_SLEEP_BIT 14
`define RPSC_REG_STATUS 7'h30
`define RPSC_READY_BIT 15
`define RPSC_XTAL_MS 3
`define RPSC_XTAL_CYCLES (`RPSC_XTAL_MS * 1000 * 1000 / (1000 / `RPSC_CLK_MHZ))
`define RPSC_REFDIV_NS 42
`define RPSC_REFDIV_CYCLES 4
`endif

// ### rtl/rpsc_top.v
// Radio power-up, init, sleep and wake control with its SPI register port
`timescale 1ns/1ps
`include "rpsc_defs.vh"
module rpsc_top
#(
  parameter XTAL_CYCLES = `RPSC_XTAL_CYCLES
)
(
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_shutdown_n,
  input wire i_spi_ss_n,
  input wire i_spi_sck,
  input wire i_spi_mosi,
  input wire i_trx_req,
  input wire i_pkt_status,
  input wire i_buf_status,
  output reg o_spi_miso,
  output reg o_spi_miso_oe,
  output reg o_buffered_ref_clock_out,
  output reg o_packet_flag_pin,
  output reg o_fifo_flag_pin,
  output reg o_framer_ready_flag,
  output reg o_sleeping,
  output reg o_xtal_stable,
  output reg o_trx_accept
);
  localparam ST_OFF = 2'h0;
  localparam ST_WAIT_INIT = 2'h1;
  localparam ST_READY = 2'h2;
  localparam ST_SLEEP = 2'h3;

  // Two-flop synchronisers for the shutdown and SPI pins; first stage read only by second
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg sck_prev_reg;
  reg ss_prev_reg;
  wire shut_n_s = sync2_reg[0];
  wire ss_n_s = sync2_reg[1];
  wire sck_s = sync2_reg[2];
  wire mosi_s = sync2_reg[3];
  // 100 MHz sampling gives at least 4 samples per half period at 12 MHz
  wire sck_rise = sck_s & ~sck_prev_reg;
  wire sck_fall = ~sck_s & sck_prev_reg;
  wire ss_rise = ss_n_s & ~ss_prev_reg;

  reg [1:0] state_reg;
  reg [5:0] bit_cnt_reg;
  reg [23:0] shift_reg;
  reg [15:0] tx_reg;
  reg sleep_bit_reg;
  reg init_done_reg;
  reg rd_cmd_reg;
  reg [31:0] xtal_cnt_reg;
  reg [2:0] div_cnt_reg;

  // Status word returned on reads of the status register
  function [15:0] status_word;
    input ready;
    begin
      status_word = 16'h0000;
      status_word[`RPSC_READY_BIT] = ready;
    end
  endfunction

  // Pin synchronisation
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sync1_reg <= 4'h3;
      sync2_reg <= 4'h3;
      sck_prev_reg <= 1'b0;
      ss_prev_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= {i_spi_mosi, i_spi_sck, i_spi_ss_n, i_shutdown_n};
      sync2_reg <= sync1_reg;
      sck_prev_reg <= sck_s;
      ss_prev_reg <= ss_n_s;
    end
  end

  // SPI slave, mode 0: first bit R/W, 7 address bits, 16 data bits
  always @(posedge i_clk)
  begin
    if (i_sys_rst || !shut_n_s)
    begin
      bit_cnt_reg <= 6'h00;
      shift_reg <= 24'h000000;
      tx_reg <= 16'h0000;
      sleep_bit_reg <= 1'b0;
      init_done_reg <= 1'b0;
      rd_cmd_reg <= 1'b0;
      o_spi_miso <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end
    else if (ss_n_s)
    begin
      bit_cnt_reg <= 6'h00;
      o_spi_miso_oe <= 1'b0;
      // A wake select must not send the block straight back to sleep
      // sleep request spent
      if (state_reg == ST_SLEEP)
        sleep_bit_reg <= 1'b0;
    end
    else
    begin
      if (sck_rise && bit_cnt_reg < 6'd24)
      begin
        shift_reg <= {shift_reg[22:0], mosi_s};
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
        // Latch the direction bit; it moves on in shift_reg with every later bit
        if (bit_cnt_reg == 6'h07)
          rd_cmd_reg <= (shift_reg[6] != `RPSC_CMD_WRITE);
        if (bit_cnt_reg == 6'h07 && shift_reg[6] != `RPSC_CMD_WRITE)
        begin
          if ({shift_reg[5:0], mosi_s} == `RPSC_REG_STATUS)
            tx_reg <= status_word(init_done_reg);
          else if ({shift_reg[5:0], mosi_s} == `RPSC_REG_SLEEP)
            tx_reg <= {1'b0, sleep_bit_reg, 14'h0000};
          else
            tx_reg <= 16'h0000;
        end
        if (bit_cnt_reg == 6'd23 && shift_reg[22] == `RPSC_CMD_WRITE)
        begin
          if (shift_reg[21:15] == `RPSC_REG_INIT && {shift_reg[14:0], mosi_s} == `RPSC_INIT_VALUE)
            init_done_reg <= 1'b1;
          if (shift_reg[21:15] == `RPSC_REG_SLEEP)
            sleep_bit_reg <= shift_reg[`RPSC_SLEEP_BIT - 1];
        end
      end
      if (sck_fall && bit_cnt_reg >= 6'h08 && bit_cnt_reg < 6'h18 && rd_cmd_reg)
      begin
        o_spi_miso_oe <= 1'b1;
        o_spi_miso <= tx_reg[15];
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
      else if (bit_cnt_reg == 6'd24 && sck_fall)
        o_spi_miso_oe <= 1'b0;
    end
  end

  // Power state machine
  always @(posedge i_clk)
  begin
    if (i_sys_rst || !shut_n_s)
    begin
      state_reg <= ST_OFF;
      xtal_cnt_reg <= 32'h00000000;
    end
    else
    begin
      case (state_reg)
        ST_OFF:
        begin
          state_reg <= ST_WAIT_INIT;
          xtal_cnt_reg <= 32'h00000000;
        end
        ST_WAIT_INIT:
          if (init_done_reg)
            state_reg <= ST_READY;
        ST_READY:
          if (sleep_bit_reg && ss_rise)
            state_reg <= ST_SLEEP;
        ST_SLEEP:
          if (!ss_n_s)
          begin
            state_reg <= ST_READY;
            xtal_cnt_reg <= 32'h00000000;
          end
        default:
          state_reg <= ST_OFF;
      endcase
      if (state_reg != ST_OFF && state_reg != ST_SLEEP && xtal_cnt_reg < XTAL_CYCLES)
        xtal_cnt_reg <= xtal_cnt_reg + 32'h00000001;
    end
  end

  // Outputs; the reference clock is a divide of i_clk, so it runs near 12.5 MHz
  always @(posedge i_clk)
  begin
    if (i_sys_rst || !shut_n_s)
    begin
      div_cnt_reg <= 3'h0;
      o_buffered_ref_clock_out <= 1'b0;
      o_packet_flag_pin <= 1'b0;
      o_fifo_flag_pin <= 1'b0;
      o_framer_ready_flag <= 1'b0;
      o_sleeping <= 1'b0;
      o_xtal_stable <= 1'b0;
      o_trx_accept <= 1'b0;
    end
    else
    begin
      if (state_reg == ST_SLEEP)
        div_cnt_reg <= 3'h0;
      else if (div_cnt_reg == `RPSC_REFDIV_CYCLES - 1)
      begin
        div_cnt_reg <= 3'h0;
        o_buffered_ref_clock_out <= ~o_buffered_ref_clock_out;
      end
      else
        div_cnt_reg <= div_cnt_reg + 3'h1;
      o_packet_flag_pin <= i_pkt_status;
      o_fifo_flag_pin <= i_buf_status;
      o_framer_ready_flag <= init_done_reg;
      o_sleeping <= (state_reg == ST_SLEEP);
      o_xtal_stable <= (xtal_cnt_reg >= XTAL_CYCLES);
      o_trx_accept <= i_trx_req && state_reg == ST_READY;
    end
  end
endmodule

// ### test/rpsc_host_model.sv
// Host side model: shutdown pulse and mode 0 SPI frames
`timescale 1ns/1ps
module rpsc_host(
  input wire i_clk,
  output logic o_shutdown_n,
  output logic o_ss_n,
  output logic o_sck,
  output logic o_mosi,
  input wire i_miso
);
  logic [15:0] rd;
  // Idle levels at time zero
  initial
  begin
    o_shutdown_n = 1;
    o_ss_n = 1;
    o_sck = 0;
    o_mosi = 0;
  end
  // Half an SPI period, four system clocks, just past the edge
  task automatic half();
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic pulse(input int us);
    o_shutdown_n = 0;
    repeat (us * 100) @(posedge i_clk);
    #1 o_shutdown_n = 1;
  endtask
  task automatic frame(input logic rw, input logic [6:0] a, input logic [15:0] d);
    logic [23:0] w;
    w = {rw, a, d};
    o_ss_n = 0;
    for (int i = 23; i >= 0; i--)
    begin
      o_mosi = w[i];
      half();
      o_sck = 1;
      rd = {rd[14:0], i_miso};
      half();
      o_sck = 0;
    end
    half();
    o_ss_n = 1;
    // Released data line must not look held
    o_mosi = ~o_mosi;
  endtask
  task automatic wake();
    o_ss_n = 0;
    half();
    o_ss_n = 1;
  endtask
endmodule

// ### test/rpsc_checker.sv
// Port assertions for the power-up and sleep controller
`timescale 1ns/1ps
module rpsc_checker(input wire i_clk, i_sys_rst, i_shutdown_n, i_spi_ss_n, i_spi_sck, i_spi_mosi,
  i_trx_req, i_pkt_status, i_buf_status, o_spi_miso, o_spi_miso_oe, o_buffered_ref_clock_out,
  o_packet_flag_pin, o_fifo_flag_pin, o_framer_ready_flag, o_sleeping, o_xtal_stable, o_trx_accept);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_clr; !i_shutdown_n [*4] |=> !o_framer_ready_flag && !o_sleeping && !o_xtal_stable; endproperty
  a_clr: assert property (p_clr) else $error("shutdown kept state");
  property p_flg; !$past(i_sys_rst) && $past(i_shutdown_n, 6) && i_shutdown_n && !o_sleeping
    |-> {o_packet_flag_pin, o_fifo_flag_pin} == $past({i_pkt_status, i_buf_status}); endproperty
  a_flg: assert property (p_flg) else $error("status pins wrong");
  property p_oe; i_spi_ss_n [*4] |=> !o_spi_miso_oe; endproperty
  a_oe: assert property (p_oe) else $error("miso driven idle");
  property p_ref; disable iff (i_sys_rst || o_sleeping || !i_shutdown_n) $rose(o_buffered_ref_clock_out)
    |-> o_buffered_ref_clock_out [*4] ##1 !o_buffered_ref_clock_out; endproperty
  a_ref: assert property (p_ref) else $error("ref clock period");
  property p_trx; i_shutdown_n && o_framer_ready_flag && o_xtal_stable && !o_sleeping && i_trx_req
    |=> o_trx_accept || $rose(o_sleeping); endproperty
  a_trx: assert property (p_trx) else $error("request refused");
  property p_wk; o_sleeping && $fell(i_spi_ss_n) |-> ##[1:6] !o_sleeping; endproperty
  a_wk: assert property (p_wk) else $error("no wake");
  property p_slp; $rose(o_sleeping) |-> $past(i_spi_ss_n, 2) && i_spi_ss_n; endproperty
  a_slp: assert property (p_slp) else $error("sleep while selected");
  property p_xt; $fell(o_sleeping) |-> ##2 !o_xtal_stable [*8]; endproperty
  a_xt: assert property (p_xt) else $error("crystal not restarted");
  c_slp: cover property ($rose(o_sleeping));
  c_rdy: cover property ($rose(o_framer_ready_flag));
  c_oe: cover property ($rose(o_spi_miso_oe));
endmodule
bind rpsc_top rpsc_checker u_chk(.*);

// ### test/rpsc_top_tb.sv
// Self-checking bench for the power-up and sleep controller
`timescale 1ns/1ps
module rpsc_top_tb;
  logic i_clk = 0, i_sys_rst = 1, i_trx_req = 0, i_pkt_status = 0, i_buf_status = 0, b;
  wire i_shutdown_n, i_spi_ss_n, i_spi_sck, i_spi_mosi, o_spi_miso, o_spi_miso_oe, o_buffered_ref_clock_out;
  wire o_packet_flag_pin, o_fifo_flag_pin, o_framer_ready_flag, o_sleeping, o_xtal_stable, o_trx_accept;
  // Released line shows the inverse, so a held value cannot pass unseen
  wire miso_w = o_spi_miso_oe ? o_spi_miso : ~o_spi_miso;
  int mismatches = 0, comparisons = 0, n;
  logic [31:0] lf = 32'hF5D1;
  rpsc_top #(.XTAL_CYCLES(50)) DUT(.*);
  rpsc_host host(.i_clk(i_clk), .o_shutdown_n(i_shutdown_n), .o_ss_n(i_spi_ss_n), .o_sck(i_spi_sck),
    .o_mosi(i_spi_mosi), .i_miso(miso_w));
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  // Hang guard, far beyond the expected run
  initial
  begin
    #300000;
    mismatches++;
    test_done();
  end
  initial
  begin
    wt(16);
    i_sys_rst = 0;
    wt(4);
    host.pulse(5);
    wt(8);
    check({o_framer_ready_flag, o_sleeping, o_spi_miso_oe}, 0);
    lf = step(lf);
    host.frame(0, 7'h1B, lf[15:0] | 16'h0001);
    wt(8);
    check(o_framer_ready_flag, 0);
    host.frame(0, 7'h1B, 16'h4200);
    wt(8);
    check(o_framer_ready_flag, 1);
    host.frame(1, 7'h30, 0);
    check(host.rd[15], 1);
    check(host.rd, 16'h8000);
    $display("init done");
    repeat (20)
    begin
      lf = step(lf);
      {i_pkt_status, i_buf_status} = lf[1:0];
      wt(1);
      check({o_packet_flag_pin, o_fifo_flag_pin}, lf[1:0]);
    end
    wt(60);
    check(o_xtal_stable, 1);
    i_trx_req = 1;
    wt(1);
    check(o_trx_accept, 1);
    n = 0;
    repeat (80)
    begin
      b = o_buffered_ref_clock_out;
      wt(1);
      n += (b !== o_buffered_ref_clock_out);
    end
    check(n, 20);
    $display("run done");
    host.frame(0, 7'h23, 16'h4000);
    wt(8);
    check(o_sleeping, 1);
    host.wake();
    wt(8);
    check({o_sleeping, o_xtal_stable}, 0);
    wt(60);
    check(o_xtal_stable, 1);
    $display("sleep done");
    host.pulse(1);
    wt(8);
    host.frame(1, 7'h23, 0);
    check(o_framer_ready_flag, 0);
    check(host.rd, 0);
    $display("shutdown done");
    test_done();
  end
endmodule
